// ### wdog_reg_if.sv
// Purpose: AXI4-Lite register slave of the watchdog timer
// Assumes: Counter and reset-cause logic live outside, same clock
// Notes:   Rules are tagged at the logic that keeps them
// Operation
// R1: Control address reads return reset-cause status
// R2: Control register write-only, one unlock field
// R3: Reload byte reads return live count byte
// R4: Reload byte writes set matching reload byte
// R5: Reload bytes upper, high, low at rising addresses
// R6: Status flags bits 7..4, bits 3..0 zero
// R7: Reserved ranges around watchdog map stay unmapped
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps

module wdog_reg_if
	import wdog_regs_pkg::*;
#(
	parameter int ADDR_W = 16
)(
	// Clock and reset
	input  wire logic                CLOCK,
	input  wire logic                RST,
	// AXI4-Lite write address and data
	input  wire logic [ADDR_W-1:0]   AWADDR,
	input  wire logic                AWVALID,
	output logic                     AWREADY,
	input  wire logic [31:0]         WDATA,
	input  wire logic [3:0]          WSTRB,
	input  wire logic                WVALID,
	output logic                     WREADY,
	// AXI4-Lite write response
	output logic [1:0]               BRESP,
	output logic                     BVALID,
	input  wire logic                BREADY,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0]   ARADDR,
	input  wire logic                ARVALID,
	output logic                     ARREADY,
	output logic [31:0]              RDATA,
	output logic [1:0]               RRESP,
	output logic                     RVALID,
	input  wire logic                RREADY,
	// Watchdog core side
	input  wire logic [COUNT_W-1:0]  WATCHDOG_COUNT,
	input  wire cause_t              RESET_CAUSE,
	output logic [COUNT_W-1:0]       RELOAD,
	output logic [7:0]               UNLOCK_DATA,
	output logic                     UNLOCK_STROBE,
	// Interrupt
	output logic                     IRQ
);

	// ==========================================================
	// Elaboration checks
	// ==========================================================
	if (ADDR_W < ADDR_W_MIN)
	begin : g_bad_addr_w
		$error("ADDR_W too narrow for the register map");
	end

	// ==========================================================
	// Address decoding
	// ==========================================================
	// Any address bit above the index field makes the access unmapped
	function automatic reg_sel_t sel_of(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-IDX_SHIFT-1:0] ix;
		ix = a[ADDR_W-1:IDX_SHIFT];
		if (ix[ADDR_W-IDX_SHIFT-1:IDX_W] != '0)
			return SEL_NONE;
		return decode_idx(ix[IDX_W-1:0]);
	endfunction : sel_of
	function automatic logic rsv_hit(input logic [ADDR_W-1:0] a);
		logic [IDX_W-1:0] ix;
		ix = a[IDX_SHIFT +: IDX_W];
		return (ix >= RSV_LO_FIRST && ix <= RSV_LO_LAST) ||
			(ix >= RSV_HI_FIRST && ix <= RSV_HI_LAST);
	endfunction : rsv_hit

	// ==========================================================
	// State
	// ==========================================================
	wr_state_t                  wr_state_q;
	wr_req_t                    wr_q;
	logic                       aw_have_q, w_have_q, awready_q, wready_q;
	logic                       bvalid_q, arready_q, rvalid_q, unlock_stb_q;
	logic [1:0]                 bresp_q, rresp_q;
	rd_state_t                  rd_state_q;
	reg_sel_t                   rd_sel_q, ar_sel;
	logic [31:0]                rdata_q;
	logic [2:0][7:0]            reload_q;
	logic [7:0]                 unlock_data_q;
	cause_t                     cause_q;
	logic [EV_W-1:0]            status_q, status_d, mask_q, events, w1c;
	logic                       irq_q, do_write, ar_take;
	assign do_write = (wr_state_q == WR_COLLECT) && aw_have_q && w_have_q;
	assign ar_take  = ARVALID && arready_q;
	assign ar_sel   = sel_of(ARADDR);

	// ==========================================================
	// Write channel
	// ==========================================================
	// Address and data are taken in either order, then one response
	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			wr_state_q <= WR_COLLECT;
			aw_have_q  <= 1'b0;
			w_have_q   <= 1'b0;
			awready_q  <= 1'b1;
			wready_q   <= 1'b1;
			bvalid_q   <= 1'b0;
			bresp_q    <= RESP_OKAY;
			wr_q       <= '{sel: SEL_NONE, data: 8'h00, lane0: 1'b0};
		end
		else
		begin
			unique case (wr_state_q)
				WR_COLLECT:
				begin
					if (AWVALID && awready_q)
					begin
						wr_q.sel  <= sel_of(AWADDR);
						aw_have_q <= 1'b1;
						awready_q <= 1'b0;
					end
					if (WVALID && wready_q)
					begin
						wr_q.data  <= WDATA[7:0]; // Upper lanes ignored
						wr_q.lane0 <= WSTRB[0];
						w_have_q   <= 1'b1;
						wready_q   <= 1'b0;
					end
					if (do_write)
					begin
						bvalid_q   <= 1'b1;
						bresp_q    <= (wr_q.sel == SEL_NONE) ?
							RESP_DECERR : RESP_OKAY; // see R7
						wr_state_q <= WR_RESP;
					end
				end
				WR_RESP:
				begin
					if (BREADY)
					begin
						bvalid_q   <= 1'b0;
						aw_have_q  <= 1'b0;
						w_have_q   <= 1'b0;
						awready_q  <= 1'b1;
						wready_q   <= 1'b1;
						wr_state_q <= WR_COLLECT;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Read channel
	// ==========================================================
	// Data is sampled at the address handshake, so a count read
	// shows the counter as it stood on that very edge
	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			rd_state_q <= RD_IDLE;
			arready_q  <= 1'b1;
			rvalid_q   <= 1'b0;
			rdata_q    <= 32'h0000_0000;
			rresp_q    <= RESP_OKAY;
			rd_sel_q   <= SEL_NONE;
		end
		else
		begin
			unique case (rd_state_q)
				RD_IDLE:
				begin
					if (ar_take)
					begin
						arready_q  <= 1'b0;
						rvalid_q   <= 1'b1;
						rd_sel_q   <= ar_sel;
						rd_state_q <= RD_RESP;
						rresp_q    <= (ar_sel == SEL_NONE) ?
							RESP_DECERR : RESP_OKAY; // see R7
						unique case (ar_sel)
							SEL_CTRL: // see R1
								rdata_q <= {24'h00_0000, cause_q,
									CAUSE_RSV}; // see R6
							SEL_UPPER: // see R3
								rdata_q <= {24'h00_0000,
									WATCHDOG_COUNT[23:16]};
							SEL_HIGH:
								rdata_q <= {24'h00_0000,
									WATCHDOG_COUNT[15:8]};
							SEL_LOW:
								rdata_q <= {24'h00_0000,
									WATCHDOG_COUNT[7:0]};
							SEL_ISTAT:
								rdata_q <= {28'h000_0000, status_q};
							SEL_IMASK:
								rdata_q <= {28'h000_0000, mask_q};
							SEL_NONE:
								rdata_q <= 32'h0000_0000;
						endcase
					end
				end
				RD_RESP:
				begin
					if (RREADY)
					begin
						rvalid_q   <= 1'b0;
						arready_q  <= 1'b1;
						rd_state_q <= RD_IDLE;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Reload bytes and unlock strobe
	// ==========================================================
	// One byte register per reload byte, all fed from lane 0, upper byte in reload_q[2] at lowest register index
	for (genvar b = 0; b < 3; b++)
	begin : g_reload
		localparam reg_sel_t BSEL = (b == 2) ? SEL_UPPER :
			(b == 1) ? SEL_HIGH : SEL_LOW; // see R5
		always_ff @(posedge CLOCK)
		begin
			if (RST)
				reload_q[b] <= RELOAD_RST[b];
			else if (do_write && wr_q.lane0 && wr_q.sel == BSEL)
				reload_q[b] <= wr_q.data; // see R4
		end
	end
	// Control writes store nothing; the unlock byte is only passed on
	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			unlock_stb_q  <= 1'b0;
			unlock_data_q <= 8'h00;
		end
		else
		begin
			unlock_stb_q <= do_write && wr_q.lane0 &&
				wr_q.sel == SEL_CTRL; // see R2
			if (do_write && wr_q.lane0 && wr_q.sel == SEL_CTRL)
				unlock_data_q <= wr_q.data; // see R2
		end
	end

	// ==========================================================
	// Reset cause and interrupts
	// ==========================================================
	// Cause flags follow the reset logic; software cannot write them
	always_ff @(posedge CLOCK)
		cause_q <= RST ? cause_t'(4'h0) : RESET_CAUSE; // see R6

	always_comb
	begin
		events = '0;
		events[EV_WDOG]    = RESET_CAUSE.watchdog_reset_flag &&
			!cause_q.watchdog_reset_flag;
		events[EV_RELOAD]  = do_write && wr_q.lane0 &&
			(wr_q.sel == SEL_UPPER || wr_q.sel == SEL_HIGH ||
			wr_q.sel == SEL_LOW);
		events[EV_UNLOCK]  = do_write && wr_q.lane0 &&
			wr_q.sel == SEL_CTRL;
		events[EV_BADADDR] = (do_write && wr_q.sel == SEL_NONE) ||
			(ar_take && ar_sel == SEL_NONE);
		w1c = '0;
		if (do_write && wr_q.lane0 && wr_q.sel == SEL_ISTAT)
			w1c = wr_q.data[EV_W-1:0];
		// A new event beats a clear in the same cycle
		status_d = (status_q & ~w1c) | events;
	end

	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			status_q <= EV_RST;
			mask_q   <= EV_RST;
			irq_q    <= 1'b0;
		end
		else
		begin
			status_q <= status_d;
			if (do_write && wr_q.lane0 && wr_q.sel == SEL_IMASK)
				mask_q <= wr_q.data[EV_W-1:0];
			irq_q <= |(status_q & mask_q);
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign AWREADY       = awready_q;
	assign WREADY        = wready_q;
	assign BVALID        = bvalid_q;
	assign BRESP         = bresp_q;
	assign ARREADY       = arready_q;
	assign RVALID        = rvalid_q;
	assign RDATA         = rdata_q;
	assign RRESP         = rresp_q;
	assign RELOAD        = reload_q;
	assign UNLOCK_DATA   = unlock_data_q;
	assign UNLOCK_STROBE = unlock_stb_q;
	assign IRQ           = irq_q;

	// ==========================================================
	// Assertions
	// ==========================================================
	// Helpers give $past plain signals to look at
	logic [7:0]  count_upper, wr_data;
	logic [15:0] reload_low16;
	logic        pend;
	assign count_upper  = WATCHDOG_COUNT[23:16];
	assign wr_data      = wr_q.data;
	assign reload_low16 = reload_q[1:0];
	assign pend         = |(status_q & mask_q);

	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (RST);
	a_shared_read: assert property ( // see R1
		ar_take && ar_sel == SEL_CTRL |=>
		rdata_q[7:CAUSE_LSB] == $past(cause_q) && rvalid_q)
		else $error("control read did not return cause flags");
	a_ctrl_no_store: assert property ( // see R2
		do_write && wr_q.lane0 && wr_q.sel == SEL_CTRL |=>
		unlock_stb_q && unlock_data_q == $past(wr_data) &&
		$stable(reload_q))
		else $error("control write stored or lost its byte");
	a_count_read: assert property ( // see R3
		ar_take && ar_sel == SEL_UPPER |=>
		rdata_q[7:0] == $past(count_upper) && rresp_q == RESP_OKAY)
		else $error("upper read did not show the live count");
	a_reload_low: assert property ( // see R4
		do_write && wr_q.lane0 && wr_q.sel == SEL_LOW |=>
		reload_q[0] == $past(wr_data) && bvalid_q)
		else $error("low reload byte not written");
	a_upper_order: assert property ( // see R5
		do_write && wr_q.lane0 && wr_q.sel == SEL_UPPER |=>
		reload_q[2] == $past(wr_data) && $stable(reload_low16))
		else $error("upper reload write hit the wrong byte");
	a_cause_low_zero: assert property ( // see R6
		rvalid_q && rd_sel_q == SEL_CTRL |->
		rdata_q[CAUSE_LSB-1:0] == CAUSE_RSV && rdata_q[31:8] == '0)
		else $error("cause register reserved bits not zero");
	a_reserved_gap: assert property ( // see R7
		ar_take && rsv_hit(ARADDR) |=>
		rresp_q == RESP_DECERR && rdata_q == '0 && status_q[EV_BADADDR])
		else $error("reserved address answered as a register");
	a_irq_follow: assert property (
		##1 irq_q == $past(pend))
		else $error("interrupt does not follow masked status");
	a_write_answer: assert property (
		do_write |=> bvalid_q [*1] ##0 !awready_q)
		else $error("write response missing");
	c_reload_write: cover property (
		do_write && wr_q.sel == SEL_HIGH ##1 BVALID && BREADY);
	c_count_read: cover property (ar_take && ar_sel == SEL_LOW);
	c_irq_rise: cover property (!irq_q ##1 irq_q);
	c_bad_read: cover property (ar_take && rsv_hit(ARADDR));

endmodule : wdog_reg_if

// ### wdog_regs_pkg.sv
// Purpose: Shared constants and types of the watchdog register interface
// Assumes: AXI4-Lite access, 32-bit data, register index times four
// Notes:   Offsets are register indices; the byte address is index * 4
package wdog_regs_pkg;

	// ==========================================================
	// Register map
	// ==========================================================
	localparam int          ADDR_W_MIN    = 16;
	localparam int          IDX_SHIFT     = 2;
	localparam int          IDX_W         = 12;
	localparam logic [11:0] IDX_CTRL      = 12'hff0; // Control / status
	localparam logic [11:0] IDX_UPPER     = 12'hff1;
	localparam logic [11:0] IDX_HIGH      = 12'hff2;
	localparam logic [11:0] IDX_LOW       = 12'hff3;
	localparam logic [11:0] IDX_ISTAT     = 12'hff6;
	localparam logic [11:0] IDX_IMASK     = 12'hff7;
	// Ranges that must stay without any register behind them
	localparam logic [11:0] RSV_LO_FIRST  = 12'hfe0;
	localparam logic [11:0] RSV_LO_LAST   = 12'hfef;
	localparam logic [11:0] RSV_HI_FIRST  = 12'hff4;
	localparam logic [11:0] RSV_HI_LAST   = 12'hff5;

	// ==========================================================
	// Field layout and reset values
	// ==========================================================
	localparam int          COUNT_W       = 24;
	localparam int          CAUSE_LSB     = 4;
	// Byte 2 is the upper byte, byte 0 the low byte
	localparam logic [2:0][7:0] RELOAD_RST = {8'h00, 8'h04, 8'h00};
	localparam logic [3:0]  CAUSE_RSV     = 4'h0;
	localparam int          EV_W          = 4;
	localparam int          EV_WDOG       = 0; // Watchdog reset flag rose
	localparam int          EV_RELOAD     = 1; // Reload byte written
	localparam int          EV_UNLOCK     = 2; // Control register written
	localparam int          EV_BADADDR    = 3; // Unmapped access
	localparam logic [3:0]  EV_RST        = 4'h0;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_DECERR   = 2'h3;

	// ==========================================================
	// Types
	// ==========================================================
	typedef enum logic [2:0] {
		SEL_CTRL,
		SEL_UPPER,
		SEL_HIGH,
		SEL_LOW,
		SEL_ISTAT,
		SEL_IMASK,
		SEL_NONE
	} reg_sel_t;

	typedef enum logic {
		WR_COLLECT,
		WR_RESP
	} wr_state_t;

	typedef enum logic {
		RD_IDLE,
		RD_RESP
	} rd_state_t;

	typedef struct packed {
		logic power_on;
		logic stop_recovery;
		logic watchdog_reset_flag;
		logic external_pin_reset_flag;
	} cause_t;

	typedef struct packed {
		reg_sel_t   sel;
		logic [7:0] data;
		logic       lane0;
	} wr_req_t;

	// Index to register selection
	function automatic reg_sel_t decode_idx(input logic [11:0] idx);
		reg_sel_t s;
		s = SEL_NONE;
		if (idx == IDX_CTRL) s = SEL_CTRL;
		if (idx == IDX_UPPER) s = SEL_UPPER;
		if (idx == IDX_HIGH) s = SEL_HIGH;
		if (idx == IDX_LOW) s = SEL_LOW;
		if (idx == IDX_ISTAT) s = SEL_ISTAT;
		if (idx == IDX_IMASK) s = SEL_IMASK;
		return s;
	endfunction : decode_idx

endpackage : wdog_regs_pkg

// ### test_watchdog_register_interface.sv
// Purpose: Self-checking bench of the watchdog register slave
// Assumes: One 200 MHz clock, AXI4-Lite master driven from here
// Notes:   Handshakes are sampled at the falling edge, driven at rising
`timescale 1ns/1ps

module test_watchdog_register_interface
	import wdog_regs_pkg::*;
();
	// ==========================================================
	// Stimulus and observed signals
	// ==========================================================
	logic        clock   = 1'b0;
	logic        rst     = 1'b1;
	logic [15:0] awaddr  = 16'h0000;
	logic [15:0] araddr  = 16'h0000;
	logic [31:0] wdata   = 32'h0000_0000;
	logic [3:0]  wstrb   = 4'h0;
	logic        awvalid = 1'b0;
	logic        wvalid  = 1'b0;
	logic        bready  = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready  = 1'b0;
	logic [23:0] count   = 24'h00_0000;
	cause_t      cause   = '0;
	logic        awready, wready, bvalid, arready, rvalid, strobe, irq;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [23:0] reload;
	logic [7:0]  unlock_data;
	int          error_cnt  = 0;
	int          num_checks = 0;
	int          strobe_cnt = 0;
	logic [11:0] rsv [4] = '{RSV_LO_FIRST, RSV_LO_LAST, RSV_HI_FIRST,
		RSV_HI_LAST};

	// 200 MHz clock
	always #2.5 clock = ~clock;

	// Strobe is one cycle wide, so one falling edge sees each pulse
	always @(negedge clock)
		if (strobe === 1'b1)
			strobe_cnt++;

	// Device under test
	wdog_reg_if #(.ADDR_W(16)) i_dut (
		.CLOCK(clock), .RST(rst),
		.AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
		.WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
		.BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
		.ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
		.RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
		.WATCHDOG_COUNT(count), .RESET_CAUSE(cause), .RELOAD(reload),
		.UNLOCK_DATA(unlock_data), .UNLOCK_STROBE(strobe), .IRQ(irq)
	);

	// ==========================================================
	// Common tasks
	// ==========================================================
	task print_verdict;
		if (error_cnt == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict

	task check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h",
				$time, seen, exp);
		end
	endtask : check

	// Write one byte; address and data released each at its own handshake
	task axi_wr(input logic [11:0] idx, input logic [7:0] d,
		input logic s, output logic [1:0] r);
		logic ta, tw, tb;
		@(posedge clock);
		awaddr  <= {2'b00, idx, 2'b00};
		wdata   <= {24'h00_0000, d};
		wstrb   <= {3'b000, s};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		tb = 1'b0;
		for (int n = 0; n < 40 && !tb; n++)
		begin
			@(negedge clock);
			ta = awvalid && awready === 1'b1;
			tw = wvalid && wready === 1'b1;
			tb = bvalid === 1'b1;
			r  = bresp;
			@(posedge clock);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) bready <= 1'b0;
		end
		if (!tb)
		begin
			error_cnt++;
			print_verdict();
		end
	endtask : axi_wr

	// Read one word; rready held until the data is seen
	task axi_rd(input logic [11:0] idx, output logic [31:0] d,
		output logic [1:0] r);
		logic ta, tr;
		@(posedge clock);
		araddr  <= {2'b00, idx, 2'b00};
		arvalid <= 1'b1;
		rready  <= 1'b1;
		tr = 1'b0;
		for (int n = 0; n < 40 && !tr; n++)
		begin
			@(negedge clock);
			ta = arvalid && arready === 1'b1;
			tr = rvalid === 1'b1;
			d  = rdata;
			r  = rresp;
			@(posedge clock);
			if (ta) arvalid <= 1'b0;
			if (tr) rready <= 1'b0;
		end
		if (!tr)
		begin
			error_cnt++;
			print_verdict();
		end
	endtask : axi_rd

	// ==========================================================
	// Scenarios
	// ==========================================================
	task t_reset;
		@(negedge clock);
		check(32'(reload), 32'h0000_0400);
		check(32'(irq), 32'h0000_0000);
	endtask : t_reset

	// Each cause flag alone lands in its own bit, low nibble stays zero
	task t_status;
		logic [31:0] d;
		logic [1:0]  r;
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clock);
			cause <= cause_t'(4'h1 << i);
			repeat (3) @(posedge clock);
			axi_rd(IDX_CTRL, d, r);
			check(d, 32'h0000_0010 << i);
			check(32'(r), 32'(RESP_OKAY));
		end
	endtask : t_status

	// Control write unlocks; reading the same place gives the status
	task t_unlock;
		logic [31:0] d;
		logic [1:0]  r;
		int          n0;
		n0 = strobe_cnt;
		axi_wr(IDX_CTRL, 8'h5a, 1'b1, r);
		check(32'(r), 32'(RESP_OKAY));
		@(negedge clock);
		check(32'(unlock_data), 32'h0000_005a);
		check(32'(strobe_cnt - n0), 32'h0000_0001);
		check(32'(reload), 32'h0000_0400);
		axi_rd(IDX_CTRL, d, r);
		check(d, 32'h0000_0080);
	endtask : t_unlock

	// Reload bytes land by address; reads return the live count instead
	task t_reload;
		logic [31:0] d;
		logic [1:0]  r;
		axi_wr(IDX_UPPER, 8'h12, 1'b1, r);
		@(negedge clock);
		check(32'(reload), 32'h0012_0400);
		axi_wr(IDX_HIGH, 8'h34, 1'b1, r);
		axi_wr(IDX_LOW, 8'h56, 1'b1, r);
		axi_wr(IDX_LOW, 8'h99, 1'b0, r);
		@(negedge clock);
		check(32'(reload), 32'h0012_3456);
		@(posedge clock);
		count <= 24'hab_cdef;
		axi_rd(IDX_UPPER, d, r);
		check(d, 32'h0000_00ab);
		axi_rd(IDX_HIGH, d, r);
		check(d, 32'h0000_00cd);
		axi_rd(IDX_LOW, d, r);
		check(d, 32'h0000_00ef);
	endtask : t_reload

	// Reserved edges of the map answer with an error and leave reload and unlock strobe unchanged
	task t_reserved;
		logic [31:0] d;
		logic [1:0]  r;
		int          n0;
		n0 = strobe_cnt;
		for (int i = 0; i < 4; i++)
		begin
			axi_rd(rsv[i], d, r);
			check(d, 32'h0000_0000);
			check(32'(r), 32'(RESP_DECERR));
			axi_wr(rsv[i], 8'h77, 1'b1, r);
			check(32'(r), 32'(RESP_DECERR));
		end
		@(negedge clock);
		check(32'(reload), 32'h0012_3456);
		check(32'(strobe_cnt - n0), 32'h0000_0000);
	endtask : t_reserved

	// Sticky events, mask, clear by writing ones
	task t_irq;
		logic [31:0] d;
		logic [1:0]  r;
		check(32'(irq), 32'h0000_0000);
		axi_rd(IDX_ISTAT, d, r);
		check(d, 32'h0000_000f);
		axi_wr(IDX_IMASK, 8'h02, 1'b1, r);
		repeat (2) @(negedge clock);
		check(32'(irq), 32'h0000_0001);
		axi_rd(IDX_IMASK, d, r);
		check(d, 32'h0000_0002);
		axi_wr(IDX_ISTAT, 8'h0f, 1'b1, r);
		repeat (2) @(negedge clock);
		check(32'(irq), 32'h0000_0000);
		axi_wr(IDX_LOW, 8'h56, 1'b1, r);
		repeat (2) @(negedge clock);
		check(32'(irq), 32'h0000_0001);
		axi_rd(IDX_ISTAT, d, r);
		check(d, 32'h0000_0002);
		axi_wr(IDX_IMASK, 8'h00, 1'b1, r);
		repeat (2) @(negedge clock);
		check(32'(irq), 32'h0000_0000);
	endtask : t_irq

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial
	begin
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		t_reset();
		t_status();
		t_unlock();
		t_reload();
		t_reserved();
		t_irq();
		print_verdict();
	end

endmodule : test_watchdog_register_interface
